// File: design/pcg_params.svh
/*
 * Register indices, field positions, reset values and timing counts of the
 * power and clock gating control block.
 * Assumes it is included by bare name from the package and the design files.
 */
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define PCG_IDX_VDC2 4'h0
`define PCG_IDX_CLK0 4'h1
`define PCG_IDX_CLK1 4'h2
`define PCG_IDX_HOSC 4'h3
`define PCG_IDX_TMR1 4'h4
`define PCG_IDX_TMR2 4'h5
`define PCG_IDX_MSTB 4'h6
`define PCG_IDX_ADC1 4'h7
`define PCG_IDX_FLC0 4'h8
`define PCG_IDX_FLC2 4'h9
`define PCG_IDX_STAT 4'hA

// Number of software written control registers, indices 0 up to this minus one.
`define PCG_NCTRL 10
// Number of mapped registers including the status register.
`define PCG_NREG 11

// Reset value of every control register.
`define PCG_REG_RST 8'h00

// Field positions in voltage_detect_ctrl2.
`define PCG_B_IPLOW 0
`define PCG_B_VDET0 5
`define PCG_B_VDET1 6
`define PCG_B_VDET2 7
// Field positions in system_clock_ctrl0, system_clock_ctrl1, high_speed_osc_ctrl.
`define PCG_B_WPCS 2
`define PCG_B_LOSTOP 4
`define PCG_B_HOEN 0
// Field position of count_source_cutoff in both timer mode registers.
`define PCG_B_CUT 7
// Field positions in module_standby_reg.
`define PCG_B_T3SB 3
`define PCG_B_T4SB 4
`define PCG_B_SERSB 5
// Field position of adc_standby_n in adc_ctrl1.
`define PCG_B_ADSB 5
// Field positions in flash_ctrl0 and flash_ctrl2.
`define PCG_B_REWR 1
`define PCG_B_FSTOP 3
`define PCG_B_LCR 7
`define PCG_LCR_MASK 8'h80
// Field positions in the status register.
`define PCG_B_SFPWR 0
`define PCG_B_SFSTP 1
`define PCG_B_SBLK 2
`define PCG_B_SHOLD 3
`define PCG_B_SPM 4

// Wait states the bus slave inserts before it answers.
`define PCG_BUS_WAIT 1

`endif

// File: design/pcg_pkg.sv
/*
 * Types shared by the power and clock gating control block.
 * Assumes pcg_params.svh is on the include path.
 */
`default_nettype none
`include "pcg_params.svh"

package pcg_pkg;
    // Power mode tracker states.
    typedef enum {
        PM_RUN,
        PM_WAIT,
        PM_STOP,
        PM_WAKE
    } pcg_pm_type;

    typedef logic [7:0] pcg_byte_type;
    typedef logic [3:0] pcg_idx_type;
endpackage

`default_nettype wire

// File: design/pcg_clk_gate.sv
/*
 * Glitch free clock gate for one gated clock.
 * Assumes the enable is stable around the falling edge of the source clock.
 */
`default_nettype none

module pcg_clk_gate (
    input wire logic clk_in,
    input wire logic rst,
    input wire logic en,
    output logic clk_out
);
    import pcg_pkg::*;

    logic en_r;

    // The enable is retimed on the falling edge, so the AND only changes
    // while the source clock is low and no runt pulse can escape.
    always_ff @(negedge clk_in) begin
        if (rst) begin
            en_r <= 1'b0;
        end else begin
            en_r <= en;
        end
    end

    assign clk_out = clk_in & en_r;
endmodule

`default_nettype wire

// File: design/pcg_avmm_slave.sv
/*
 * Avalon-MM slave front end of the control registers, one wait state.
 * Assumes the master holds its request until waitrequest is seen low.
 */
`default_nettype none
`include "pcg_params.svh"

module pcg_avmm_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output pcg_pkg::pcg_idx_type reg_idx,
    output logic reg_wr,
    output pcg_pkg::pcg_byte_type reg_wdata,
    input wire pcg_pkg::pcg_byte_type reg_rdata
);
    import pcg_pkg::*;

    logic ack_r;
    logic [31:0] rdata_r;
    wire req = avs_read | avs_write;
    wire mapped = (reg_idx < 4'(`PCG_NREG));

    // Word index decode; only the low byte lane carries register data.
    assign reg_idx = avs_address[5:2];
    assign reg_wdata = avs_writedata[7:0];
    assign reg_wr = avs_write & ack_r & avs_byteenable[0] & mapped;
    assign avs_waitrequest = req & ~ack_r;
    assign avs_readdata = rdata_r;

    // Read data is captured in the wait cycle so it stands at the accepting
    // edge; unmapped words read as zero and writes to them are dropped.
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r <= req & ~ack_r;
            rdata_r <= (avs_read & mapped) ? {24'h0, reg_rdata} : 32'h0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_bus_wait: assert property (req && !ack_r |=> !avs_waitrequest) // RULE_18
        else $error("slave did not answer after one wait state");
endmodule

`default_nettype wire

// File: design/pcg_ctrl.sv
/*
 * Power and clock gating control: control registers, power mode tracking,
 * clock gates, flash power and access gating.
 * Assumes wait_mode, stop_mode and low_speed_mode come synchronous to clk
 * from the core, and that the gated source clocks are free running.
 */
// Implementation choices: the address map and register access over Avalon-MM.
// Functional notes
// RULE_01 - vdet1_enable at 0 disables detection 1.
// RULE_02 - vdet2_enable at 0 disables detection 2.
// RULE_03 - vdet0_enable at 0 disables detection 0.
// RULE_04 - Port states held in wait and stop.
// RULE_05 - wait_periph_clk_stop halts f1..f32 in wait.
// RULE_06 - count_source_cutoff disconnects timer count source.
// RULE_07 - third_timer_standby puts that timer in standby.
// RULE_08 - adc_standby_n at 0 powers converter down.
// RULE_09 - serial_unit_standby stops serial and I2C units.
// RULE_10 - Separate stop controls for both on-chip oscillators.
// RULE_11 - flash_stop stops flash and blocks access.
// RULE_12 - Software changes flash_stop only from RAM.
// RULE_13 - Flash powered off automatically in wait/stop; the code keeps it powered while the rewrite bit of flash_ctrl0 is set.
// RULE_14 - Low-current flash read in low-speed modes.
// RULE_15 - fourth_timer_standby reduces that peripheral's power.
// RULE_16 - internal_power_low_sel cuts power in low-speed wait.
// RULE_17 - Set low_current_read_enable by writing 0 then 1.
// RULE_18 - Controls act next edge, gated clocks glitch free.
// RULE_19 - Blocked flash access reported, never stale data.
`default_nettype none
`include "pcg_params.svh"

module pcg_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic low_speed_mode,
    input wire logic [4:0] periph_clk_in,
    input wire logic [1:0] timer_src_in,
    input wire logic flash_req,
    output logic [4:0] periph_clk_out,
    output logic [1:0] timer_clk_out,
    output logic vdet0_en,
    output logic vdet1_en,
    output logic vdet2_en,
    output logic low_osc_run,
    output logic high_osc_run,
    output logic timer3_standby,
    output logic timer4_standby,
    output logic serial_standby,
    output logic adc_power,
    output logic flash_power,
    output logic flash_stopped,
    output logic flash_low_read,
    output logic internal_power_low,
    output logic port_hold,
    output logic flash_grant,
    output logic flash_blocked
);
    import pcg_pkg::*;

    pcg_idx_type reg_idx;
    pcg_byte_type reg_wdata;
    pcg_byte_type reg_rdata;
    pcg_byte_type wdata_eff;
    pcg_byte_type status;
    logic reg_wr;
    pcg_byte_type ctrl_r [0:`PCG_NCTRL-1];
    pcg_pm_type pm_r;
    pcg_pm_type pm_nxt;
    logic lcr_arm_r;
    logic ls_entry_r;
    logic blk_sticky_r;
    logic flash_power_r;
    logic port_hold_r;
    logic grant_r;
    logic blocked_r;
    logic low_read_r;
    logic ipl_r;
    logic [6:0] gate_en;
    logic [6:0] g_out;

    pcg_avmm_slave u_bus (
        .clk(clk),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .reg_idx(reg_idx),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata)
    );

    // Named control fields taken from the register array.
    wire f_vdet0 = ctrl_r[`PCG_IDX_VDC2][`PCG_B_VDET0];
    wire f_vdet1 = ctrl_r[`PCG_IDX_VDC2][`PCG_B_VDET1];
    wire f_vdet2 = ctrl_r[`PCG_IDX_VDC2][`PCG_B_VDET2];
    wire f_iplow = ctrl_r[`PCG_IDX_VDC2][`PCG_B_IPLOW];
    wire f_wpcs = ctrl_r[`PCG_IDX_CLK0][`PCG_B_WPCS];
    wire f_lostop = ctrl_r[`PCG_IDX_CLK1][`PCG_B_LOSTOP];
    wire f_hoen = ctrl_r[`PCG_IDX_HOSC][`PCG_B_HOEN];
    wire f_cut1 = ctrl_r[`PCG_IDX_TMR1][`PCG_B_CUT];
    wire f_cut2 = ctrl_r[`PCG_IDX_TMR2][`PCG_B_CUT];
    wire f_t3sb = ctrl_r[`PCG_IDX_MSTB][`PCG_B_T3SB];
    wire f_t4sb = ctrl_r[`PCG_IDX_MSTB][`PCG_B_T4SB];
    wire f_sersb = ctrl_r[`PCG_IDX_MSTB][`PCG_B_SERSB];
    wire f_adsb = ctrl_r[`PCG_IDX_ADC1][`PCG_B_ADSB];
    wire f_rewr = ctrl_r[`PCG_IDX_FLC0][`PCG_B_REWR];
    wire f_fstop = ctrl_r[`PCG_IDX_FLC0][`PCG_B_FSTOP];
    wire f_lcr = ctrl_r[`PCG_IDX_FLC2][`PCG_B_LCR];

    // Write strobes per register of interest.
    wire wr_vdc2 = reg_wr && reg_idx == `PCG_IDX_VDC2;
    wire wr_clk1 = reg_wr && reg_idx == `PCG_IDX_CLK1;
    wire wr_hosc = reg_wr && reg_idx == `PCG_IDX_HOSC;
    wire wr_tmr1 = reg_wr && reg_idx == `PCG_IDX_TMR1;
    wire wr_tmr2 = reg_wr && reg_idx == `PCG_IDX_TMR2;
    wire wr_mstb = reg_wr && reg_idx == `PCG_IDX_MSTB;
    wire wr_adc1 = reg_wr && reg_idx == `PCG_IDX_ADC1;
    wire wr_flc2 = reg_wr && reg_idx == `PCG_IDX_FLC2;
    wire wr_stat = reg_wr && reg_idx == `PCG_IDX_STAT;

    // A 1 into low_current_read_enable only lands when the write before it
    // wrote 0 there; any other write in between disarms the sequence.
    wire lcr_block = wr_flc2 && reg_wdata[`PCG_B_LCR] && !lcr_arm_r; // RULE_17
    assign wdata_eff = lcr_block ?
        ((reg_wdata & ~`PCG_LCR_MASK) | (ctrl_r[`PCG_IDX_FLC2] & `PCG_LCR_MASK)) :
        reg_wdata;

    // Mode tracking helpers.
    wire sleep = (pm_r == PM_WAIT) || (pm_r == PM_STOP);
    wire access_ok = flash_power_r && !f_fstop && pm_r == PM_RUN; // RULE_11
    wire blk_evt = flash_req && !access_ok; // RULE_19

    // Status word: flash power, flash stop, sticky blocked flag, port hold, mode.
    assign status = {2'b00, 2'(pm_r), port_hold_r, blk_sticky_r, f_fstop, flash_power_r};
    assign reg_rdata = (reg_idx == `PCG_IDX_STAT) ? status :
        (reg_idx < 4'(`PCG_NCTRL)) ? ctrl_r[reg_idx] : 8'h00;

    // Control registers, one per index; a write lands on its accepting edge
    // and the controlled logic sees it from the next edge.
    genvar gi;
    generate
        for (gi = 0; gi < `PCG_NCTRL; gi++) begin : g_reg
            always_ff @(posedge clk) begin
                if (rst) begin
                    ctrl_r[gi] <= `PCG_REG_RST;
                end else if (reg_wr && reg_idx == 4'(gi)) begin
                    ctrl_r[gi] <= wdata_eff; // RULE_18
                end
            end
        end
    endgenerate

    // Arm flag of the write-0-then-1 sequence.
    always_ff @(posedge clk) begin
        if (rst) begin
            lcr_arm_r <= 1'b0;
        end else if (reg_wr) begin
            lcr_arm_r <= wr_flc2 && !reg_wdata[`PCG_B_LCR]; // RULE_17
        end
    end

    // Power mode tracker; a stop request wins over a wait request, and one
    // wake cycle lets flash power settle before access reopens.
    always_comb begin
        pm_nxt = pm_r;
        case (pm_r)
            PM_RUN: begin
                if (stop_mode) begin
                    pm_nxt = PM_STOP;
                end else if (wait_mode) begin
                    pm_nxt = PM_WAIT;
                end
            end
            PM_WAIT, PM_STOP: begin
                if (!wait_mode && !stop_mode) begin
                    pm_nxt = PM_WAKE;
                end
            end
            PM_WAKE: pm_nxt = PM_RUN;
            default: pm_nxt = PM_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pm_r <= PM_RUN;
            ls_entry_r <= 1'b0;
        end else begin
            pm_r <= pm_nxt;
            if (pm_r == PM_RUN && pm_nxt == PM_WAIT) begin
                ls_entry_r <= low_speed_mode;
            end
        end
    end

    // Mode driven outputs, all from flops.
    always_ff @(posedge clk) begin
        if (rst) begin
            flash_power_r <= 1'b1;
            port_hold_r <= 1'b0;
            low_read_r <= 1'b0;
            ipl_r <= 1'b0;
        end else begin
            flash_power_r <= !(sleep && !f_rewr); // RULE_13
            port_hold_r <= sleep; // RULE_04
            low_read_r <= f_lcr && low_speed_mode; // RULE_14
            ipl_r <= f_iplow && pm_r == PM_WAIT && ls_entry_r; // RULE_16
        end
    end

    // Flash access answers; the sticky flag lets software see a blocked
    // access it missed, and a new block in the clearing cycle wins.
    always_ff @(posedge clk) begin
        if (rst) begin
            grant_r <= 1'b0;
            blocked_r <= 1'b0;
            blk_sticky_r <= 1'b0;
        end else begin
            grant_r <= flash_req && access_ok; // RULE_11
            blocked_r <= blk_evt; // RULE_19
            blk_sticky_r <= blk_evt || (blk_sticky_r && !(wr_stat && reg_wdata[`PCG_B_SBLK]));
        end
    end

    // Gate enables; the peripheral clocks stop only while wait lasts.
    assign gate_en[4:0] = {5{!(pm_r == PM_WAIT && f_wpcs)}}; // RULE_05
    assign gate_en[5] = !f_cut1; // RULE_06
    assign gate_en[6] = !f_cut2; // RULE_06

    // Gate sources in gate order, peripheral clocks first; one flat vector
    // keeps every index of the loop below in range.
    wire [6:0] gate_src = {timer_src_in, periph_clk_in};

    // One glitch free gate per gated clock.
    generate
        for (gi = 0; gi < 7; gi++) begin : g_gate
            pcg_clk_gate u_gate (
                .clk_in(gate_src[gi]),
                .rst(rst),
                .en(gate_en[gi]),
                .clk_out(g_out[gi])
            );
        end
    endgenerate

    // Output assignments; register bits drive the analog and standby controls.
    assign vdet0_en = f_vdet0; // RULE_03
    assign vdet1_en = f_vdet1; // RULE_01
    assign vdet2_en = f_vdet2; // RULE_02
    assign low_osc_run = !f_lostop; // RULE_10
    assign high_osc_run = f_hoen; // RULE_10
    assign timer3_standby = f_t3sb; // RULE_07
    assign timer4_standby = f_t4sb; // RULE_15
    assign serial_standby = f_sersb; // RULE_09
    assign adc_power = f_adsb; // RULE_08
    assign flash_power = flash_power_r;
    assign flash_stopped = f_fstop;
    assign flash_low_read = low_read_r;
    assign internal_power_low = ipl_r;
    assign port_hold = port_hold_r;
    assign flash_grant = grant_r;
    assign flash_blocked = blocked_r;
    assign periph_clk_out = g_out[4:0];
    assign timer_clk_out = g_out[6:5];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_vdet1_clear: assert property (wr_vdc2 && !reg_wdata[6] |=> !vdet1_en) // RULE_01
        else $error("detection 1 still enabled after clear");
    a_vdet2_clear: assert property (wr_vdc2 && !reg_wdata[7] |=> !vdet2_en) // RULE_02
        else $error("detection 2 still enabled after clear");
    a_vdet0_clear: assert property (wr_vdc2 && !reg_wdata[5] |=> !vdet0_en) // RULE_03
        else $error("detection 0 still enabled after clear");
    a_port_hold: assert property (sleep |=> port_hold) // RULE_04
        else $error("ports not held in wait or stop");
    a_periph_gate: assert property (pm_r == PM_WAIT && f_wpcs |-> gate_en[4:0] == 5'h00) // RULE_05
        else $error("peripheral clocks enabled in wait");
    a_timer_cut: assert property (wr_tmr1 && reg_wdata[7] |=> !gate_en[5]) // RULE_06
        else $error("first timer count source not cut");
    a_timer2_cut: assert property (wr_tmr2 && reg_wdata[7] |=> !gate_en[6]) // RULE_06
        else $error("second timer count source not cut");
    a_timer3_stby: assert property (wr_mstb && reg_wdata[3] |=> timer3_standby) // RULE_07
        else $error("third timer not in standby");
    a_adc_stby: assert property (wr_adc1 && !reg_wdata[5] |=> !adc_power) // RULE_08
        else $error("converter still powered");
    a_serial_stby: assert property (wr_mstb && reg_wdata[5] |=> serial_standby) // RULE_09
        else $error("serial units not in standby");
    a_losc_stop: assert property (wr_clk1 && reg_wdata[4] |=> !low_osc_run) // RULE_10
        else $error("low speed oscillator still running");
    a_hosc_stop: assert property (wr_hosc && !reg_wdata[0] |=> !high_osc_run) // RULE_10
        else $error("high speed oscillator still running");
    a_flash_stop: assert property (f_fstop && flash_req |=> flash_blocked && !flash_grant) // RULE_11
        else $error("access granted to stopped flash");
    a_flash_auto: assert property (sleep && !f_rewr ##1 pm_r == PM_WAKE |-> !flash_power ##1 flash_power) // RULE_13
        else $error("flash power not cycled around sleep");
    a_low_read: assert property (flash_low_read |-> $past(f_lcr) && $past(low_speed_mode)) // RULE_14
        else $error("low current read outside low speed mode");
    a_timer4_stby: assert property (wr_mstb && reg_wdata[4] |=> timer4_standby) // RULE_15
        else $error("fourth timer not in reduced power");
    a_int_power: assert property (pm_r == PM_WAIT && f_iplow && ls_entry_r |=> internal_power_low) // RULE_16
        else $error("internal power not reduced");
    a_lcr_seq: assert property (wr_flc2 && reg_wdata[7] && !lcr_arm_r && !f_lcr |=> !f_lcr) // RULE_17
        else $error("unarmed write set low current read");
    a_block_report: assert property (flash_req && !flash_power |=> flash_blocked) // RULE_19
        else $error("access to unpowered flash not reported");
endmodule

`default_nettype wire

// File: bench/tb.sv
/*
 * Self-checking bench for the power and clock gating control block.
 * Assumes the design files and pcg_params.svh are compiled first.
 */
`default_nettype none
`include "pcg_params.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pcg_pkg::*;

    logic clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd_data;
    logic [3:0] avs_byteenable;
    logic wait_mode, stop_mode, low_speed_mode, flash_req;
    logic [4:0] periph_clk_in = 5'h00, periph_clk_out, seen_p;
    logic [1:0] timer_src_in = 2'h0, timer_clk_out, seen_t;
    logic vdet0_en, vdet1_en, vdet2_en, low_osc_run, high_osc_run;
    logic timer3_standby, timer4_standby, serial_standby, adc_power;
    logic flash_power, flash_stopped, flash_low_read, internal_power_low;
    logic port_hold, flash_grant, flash_blocked;
    int err_count, checks;

    pcg_ctrl pcg_ctrl_i (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .wait_mode(wait_mode), .stop_mode(stop_mode),
        .low_speed_mode(low_speed_mode), .periph_clk_in(periph_clk_in),
        .timer_src_in(timer_src_in), .flash_req(flash_req),
        .periph_clk_out(periph_clk_out), .timer_clk_out(timer_clk_out),
        .vdet0_en(vdet0_en), .vdet1_en(vdet1_en), .vdet2_en(vdet2_en),
        .low_osc_run(low_osc_run), .high_osc_run(high_osc_run),
        .timer3_standby(timer3_standby), .timer4_standby(timer4_standby),
        .serial_standby(serial_standby), .adc_power(adc_power),
        .flash_power(flash_power), .flash_stopped(flash_stopped),
        .flash_low_read(flash_low_read), .internal_power_low(internal_power_low),
        .port_hold(port_hold), .flash_grant(flash_grant), .flash_blocked(flash_blocked)
    );

    // The 100 ns system clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Free-running sources that the gates pass or block, toggled every cycle.
    always @(posedge clk) begin
        periph_clk_in <= ~periph_clk_in;
        timer_src_in <= ~timer_src_in;
    end

    // Compares one value and counts the outcome.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One Avalon-MM access; the request is held until waitrequest is seen low
    // at a rising edge, where the write lands and read data is taken.
    task automatic bus(input logic wr, input logic [5:0] addr, input logic [7:0] data,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= addr;
        avs_writedata <= {24'h000000, data};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        check("bus answer", {31'h0, avs_waitrequest}, 32'h0);
        rd_data = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(negedge clk);
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] data);
        bus(1'b1, {idx, 2'b00}, data, 4'h1);
    endtask

    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
        bus(1'b0, {idx, 2'b00}, 8'h00, 4'h1);
        check("register read", rd_data, {24'h000000, exp});
    endtask

    // Packs the static control outputs so one table line checks them all.
    function automatic logic [8:0] outs();
        return {vdet2_en, vdet1_en, vdet0_en, low_osc_run, high_osc_run,
                timer3_standby, timer4_standby, serial_standby, adc_power};
    endfunction

    task automatic wr_chk(input logic [3:0] idx, input logic [7:0] data, input logic [8:0] exp);
        wr(idx, data);
        check("control outputs", {23'h0, outs()}, {23'h0, exp});
    endtask

    // Records which gated clocks showed a high level over sixteen cycles.
    // Two cycles pass first, since an enable reaches its gate only at a
    // falling edge of the source.
    task automatic watch();
        repeat (2) @(negedge clk);
        seen_p = 5'h00;
        seen_t = 2'h0;
        repeat (16) begin
            @(negedge clk);
            seen_p = seen_p | periph_clk_out;
            seen_t = seen_t | timer_clk_out;
        end
    endtask

    // A single-cycle flash access attempt; exp is {grant, blocked}.
    task automatic flash_try(input logic [1:0] exp);
        @(posedge clk);
        flash_req <= 1'b1;
        @(posedge clk);
        flash_req <= 1'b0;
        @(negedge clk);
        check("flash answer", {30'h0, flash_grant, flash_blocked}, {30'h0, exp});
    endtask

    task automatic set_modes(input logic w, input logic s);
        @(posedge clk);
        wait_mode <= w;
        stop_mode <= s;
        repeat (4) @(negedge clk);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // The whole run takes well under 2000 cycles, so 20000 means a hang.
    initial begin
        #2000000;
        err_count++;
        report_and_stop();
    end

    // Main sequence.
    initial begin
        rst = 1'b1;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        wait_mode = 1'b0;
        stop_mode = 1'b0;
        low_speed_mode = 1'b0;
        flash_req = 1'b0;
        err_count = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(negedge clk);
        check("reset outputs", {23'h0, outs()}, 32'h020);
        check("reset flash power", {31'h0, flash_power}, 32'h1);
        for (int i = 0; i < `PCG_NCTRL; i++) begin
            rd_chk(i[3:0], `PCG_REG_RST);
        end
        rd_chk(`PCG_IDX_STAT, 8'h01);
        rd_chk(4'hB, 8'h00);
        watch();
        check("open gates", {27'h0, seen_p, seen_t}, 32'h7F);
        $display("test reset done");

        wr_chk(`PCG_IDX_VDC2, 8'hE0, 9'h1E0);
        wr_chk(`PCG_IDX_VDC2, 8'h40, 9'h0A0);
        wr_chk(`PCG_IDX_VDC2, 8'hA0, 9'h160);
        wr_chk(`PCG_IDX_CLK1, 8'h10, 9'h140);
        wr_chk(`PCG_IDX_HOSC, 8'h01, 9'h150);
        wr_chk(`PCG_IDX_MSTB, 8'h08, 9'h158);
        wr_chk(`PCG_IDX_MSTB, 8'h10, 9'h154);
        wr_chk(`PCG_IDX_MSTB, 8'h20, 9'h152);
        wr_chk(`PCG_IDX_ADC1, 8'h20, 9'h153);
        wr_chk(`PCG_IDX_ADC1, 8'h00, 9'h152);
        rd_chk(`PCG_IDX_VDC2, 8'hA0);
        rd_chk(`PCG_IDX_MSTB, 8'h20);
        bus(1'b1, {`PCG_IDX_HOSC, 2'b00}, 8'h00, 4'h0);
        check("masked write", {23'h0, outs()}, 32'h152);
        bus(1'b1, 6'h2C, 8'hFF, 4'h1);
        rd_chk(4'hB, 8'h00);
        wr(`PCG_IDX_STAT, 8'hFB);
        rd_chk(`PCG_IDX_STAT, 8'h01);
        wr(`PCG_IDX_CLK1, 8'h00);
        wr(`PCG_IDX_HOSC, 8'h00);
        wr(`PCG_IDX_MSTB, 8'h00);
        $display("test controls done");

        wr(`PCG_IDX_TMR1, 8'h80);
        watch();
        check("first timer cut", {30'h0, seen_t}, 32'h2);
        wr(`PCG_IDX_TMR2, 8'h80);
        watch();
        check("both timers cut", {30'h0, seen_t}, 32'h0);
        wr(`PCG_IDX_TMR1, 8'h00);
        wr(`PCG_IDX_TMR2, 8'h00);
        $display("test timers done");

        wr(`PCG_IDX_FLC0, 8'h08);
        check("flash stopped", {31'h0, flash_stopped}, 32'h1);
        flash_try(2'b01);
        rd_chk(`PCG_IDX_STAT, 8'h07);
        wr(`PCG_IDX_STAT, 8'h04);
        rd_chk(`PCG_IDX_STAT, 8'h03);
        wr(`PCG_IDX_FLC0, 8'h00);
        flash_try(2'b10);
        $display("test flash stop done");

        @(posedge clk);
        low_speed_mode <= 1'b1;
        wr(`PCG_IDX_FLC2, 8'h80);
        rd_chk(`PCG_IDX_FLC2, 8'h00);
        check("low read off", {31'h0, flash_low_read}, 32'h0);
        wr(`PCG_IDX_FLC2, 8'h00);
        wr(`PCG_IDX_FLC2, 8'h80);
        rd_chk(`PCG_IDX_FLC2, 8'h80);
        check("low read on", {31'h0, flash_low_read}, 32'h1);
        @(posedge clk);
        low_speed_mode <= 1'b0;
        repeat (2) @(negedge clk);
        check("low read fast", {31'h0, flash_low_read}, 32'h0);
        wr(`PCG_IDX_FLC2, 8'h00);
        $display("test low current read done");

        wr(`PCG_IDX_CLK0, 8'h04);
        wr(`PCG_IDX_VDC2, 8'h01);
        @(posedge clk);
        low_speed_mode <= 1'b1;
        set_modes(1'b1, 1'b0);
        check("port hold wait", {31'h0, port_hold}, 32'h1);
        check("flash off wait", {31'h0, flash_power}, 32'h0);
        check("internal low", {31'h0, internal_power_low}, 32'h1);
        watch();
        check("periph gated", {25'h0, seen_p, seen_t}, 32'h03);
        flash_try(2'b01);
        rd_chk(`PCG_IDX_STAT, 8'h1C);
        set_modes(1'b0, 1'b0);
        check("port free", {31'h0, port_hold}, 32'h0);
        check("flash back", {31'h0, flash_power}, 32'h1);
        watch();
        check("periph run", {27'h0, seen_p}, 32'h1F);
        flash_try(2'b10);
        wr(`PCG_IDX_STAT, 8'h04);
        wr(`PCG_IDX_CLK0, 8'h00);
        wr(`PCG_IDX_FLC0, 8'h02);
        set_modes(1'b1, 1'b0);
        check("flash kept", {31'h0, flash_power}, 32'h1);
        watch();
        check("periph ungated", {27'h0, seen_p}, 32'h1F);
        set_modes(1'b0, 1'b0);
        wr(`PCG_IDX_FLC0, 8'h00);
        set_modes(1'b1, 1'b1);
        check("flash off stop", {31'h0, flash_power}, 32'h0);
        rd_chk(`PCG_IDX_STAT, 8'h28);
        set_modes(1'b0, 1'b0);
        check("flash after stop", {31'h0, flash_power}, 32'h1);
        $display("test power modes done");
        report_and_stop();
    end
endmodule

`default_nettype wire
